// [design/pin_strap_params.svh]
// Register map, field positions, reset values and synchroniser depth
`ifndef PIN_STRAP_PARAMS_SVH
`define PIN_STRAP_PARAMS_SVH

// Bus widths
`define ADDR_W 8
`define DATA_W 32

// Register byte offsets
`define REG_PROBE 8'h00
`define REG_PIN_CFG 8'h04
`define REG_EE_CTRL 8'h08
`define REG_PM_CTRL 8'h0C
`define REG_STATUS 8'h10
`define REG_INT_STATUS 8'h14
`define REG_INT_MASK 8'h18

// Arbitrary fixed pattern returned by the probe register
`define PROBE_VALUE 32'h8765_4321

// Pin configuration fields
`define CFG_W 8
`define CFG_DATA_ROLE 0
`define CFG_CLK_ROLE 2
`define ROLE_W 2
`define CFG_GENERAL_OUTPUT_THREE 4
`define CFG_GENERAL_OUTPUT_FOUR 5
`define CFG_MDIX_MANUAL 6
`define CFG_MDIX_AUTO 7
`define CFG_RESET 8'h80

// EEPROM bit-bang control fields
`define EE_W 4
`define EE_SEL 0
`define EE_CLK 1
`define EE_DOUT 2
`define EE_DOE 3
`define EE_RESET 4'h0

// Power control fields; the sleep bit is an action, not stored
`define PM_W 3
`define PM_WAKE_EN 0
`define PM_POL 1
`define PM_OD 2
`define PM_SLEEP 3
`define PM_RESET 3'h0

// Status fields
`define ST_STRAP 0
`define ST_SPEED100 1
`define ST_AUTONEG 2
`define ST_SWAP 3
`define ST_SLEEP 4
`define ST_EE_DIN 5
`define ST_READ_SEEN 6

// Interrupt status and mask fields
`define INT_W 3
`define INT_WAKE_EVENT 0
`define INT_HOST_WAKE 1
`define INT_WR_DROPPED 2
`define INT_RESET 3'h0

// Reset synchroniser depth
`define SYNC_W 2
`define SYNC_RESET 2'h0

`endif

// [design/pin_strap_pkg.sv]
// Types shared by the pin, strap and wake logic
package pin_strap_pkg;
	typedef enum logic [1:0] {
		DATA_EEPROM,
		DATA_GPO,
		DATA_TX_EN,
		DATA_TX_CLK
	} data_role_t;

	typedef enum logic [1:0] {
		CLK_EEPROM,
		CLK_GPO,
		CLK_RX_DV,
		CLK_RX_CLK
	} clk_role_t;

	typedef enum logic {
		PM_AWAKE,
		PM_SLEEP
	} pm_state_t;
endpackage

// [design/reset_strap_if.sv]
// Synchronised reset and latched strap passed to the pin logic
`timescale 1ns/10ps
`default_nettype none
interface reset_strap_if;
	logic rst_n;
	logic strap_valid;
	logic strap;
	modport src (output rst_n, output strap_valid, output strap);
	modport dst (input rst_n, input strap_valid, input strap);
endinterface
`default_nettype wire

// [design/reset_strap.sv]
// Reset release synchroniser and link default strap latch
`timescale 1ns/10ps
`default_nettype none
`include "pin_strap_params.svh"
module reset_strap (
	// Clock and raw reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Strap pin
	input wire logic strap_in,
	// Results
	reset_strap_if.src rs
);
	logic [`SYNC_W-1:0] sync;
	logic [`SYNC_W-1:0] next_sync;
	logic taken;
	logic next_taken;
	logic strap;
	logic next_strap;

	always_comb begin
		next_sync = {sync[0], 1'b1};
		next_taken = taken | sync[1];
		next_strap = strap;
		// Caught one edge after release, never under the async reset
		if (sync[1] && !taken) begin
			next_strap = strap_in;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sync <= `SYNC_RESET;
			taken <= 1'b0;
			strap <= 1'b0;
		end else begin
			sync <= next_sync;
			taken <= next_taken;
			strap <= next_strap;
		end
	end

	assign rs.rst_n = sync[1];
	assign rs.strap_valid = taken;
	assign rs.strap = strap;

	AST_STRAP_LATCH: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$rose(sync[1]) |=> (taken && strap == $past(strap_in)))
		else $error("strap not latched at reset release");
	AST_STRAP_HOLD: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		taken |=> $stable(strap))
		else $error("strap changed after latch");
	AST_RESET_SYNC: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$rose(sync[0]) |-> !sync[1] ##1 sync[1])
		else $error("reset release not two stages");
endmodule // reset_strap
`default_nettype wire

// [design/pin_strap_mux_wake_control.sv]
// Strap, crossover, EEPROM pin mux, wake indicator and host wake control
`timescale 1ns/10ps
`default_nettype none
`include "pin_strap_params.svh"
module pin_strap_mux_wake_control (
	// Clock and resets
	input wire logic SYS_CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic POWER_ON_RESET_N_IN,
	// Strap
	input wire logic LINK_DEFAULT_STRAP_IN,
	// Register port
	input wire logic [`ADDR_W-1:0] REG_ADDR_IN,
	input wire logic [`DATA_W-1:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	output logic [`DATA_W-1:0] REG_RDATA_OUT,
	// Host bus wake pins
	input wire logic CHIP_SELECT_N_IN,
	input wire logic WRITE_STROBE_N_IN,
	// Wake source and crossover detect
	input wire logic WAKE_EVENT_IN,
	input wire logic LINK_REVERSED_IN,
	// Internal MII signals for monitoring
	input wire logic MII_TX_EN_IN,
	input wire logic MII_TX_CLK_IN,
	input wire logic MII_RX_DV_IN,
	input wire logic MII_RX_CLK_IN,
	// EEPROM pins
	input wire logic EEPROM_DATA_PIN_IN,
	output logic EEPROM_DATA_PIN_OUT,
	output logic EEPROM_DATA_PIN_OE_N_OUT,
	output logic EEPROM_CLOCK_PIN_OUT,
	output logic EEPROM_SELECT_OUT,
	// Wake indicator pin
	output logic WAKE_INDICATOR_OUT,
	output logic WAKE_INDICATOR_OE_N_OUT,
	// Twisted pair roles and link defaults
	output logic PAIR_A_TRANSMIT_OUT,
	output logic PAIR_B_TRANSMIT_OUT,
	output logic LINK_SPEED_100_OUT,
	output logic LINK_FULL_DUPLEX_OUT,
	output logic LINK_AUTONEG_OUT,
	// Status
	output logic SLEEPING_OUT,
	output logic IRQ_OUT
);
	function automatic logic hit(input logic [`ADDR_W-1:0] a,
		input logic [`ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	reset_strap_if rs ();
	logic raw_rst_n;
	// Either the pin or the internal power-on source resets everything
	assign raw_rst_n = ARST_N_IN & POWER_ON_RESET_N_IN;

	reset_strap u_reset_strap (
		.clk_in(SYS_CLK_IN),
		.arst_n_in(raw_rst_n),
		.strap_in(LINK_DEFAULT_STRAP_IN),
		.rs(rs.src)
	);

	logic rst_n;
	assign rst_n = rs.rst_n;

	// Register and power state
	logic [`CFG_W-1:0] cfg, next_cfg;
	logic [`EE_W-1:0] ee, next_ee;
	logic [`PM_W-1:0] pm, next_pm;
	logic [`INT_W-1:0] int_status, next_int_status;
	logic [`INT_W-1:0] int_mask, next_int_mask;
	logic [`DATA_W-1:0] rdata, next_rdata;
	logic read_seen, next_read_seen;
	logic pending, next_pending;
	logic irq, next_irq;
	pin_strap_pkg::pm_state_t state, next_state;
	logic wr_ok;
	logic host_wake;
	logic [`DATA_W-1:0] rd_val;

	// Pin state
	logic d_out, next_d_out;
	logic d_oe_n, next_d_oe_n;
	logic c_out, next_c_out;
	logic sel, next_sel;
	logic swap, next_swap;
	logic w_out, next_w_out;
	logic w_oe_n, next_w_oe_n;
	logic din, next_din;
	pin_strap_pkg::data_role_t drole;
	pin_strap_pkg::clk_role_t crole;
	logic w_lvl;

	assign drole = pin_strap_pkg::data_role_t'(cfg[`CFG_DATA_ROLE +: `ROLE_W]);
	assign crole = pin_strap_pkg::clk_role_t'(cfg[`CFG_CLK_ROLE +: `ROLE_W]);

	always_comb begin
		next_cfg = cfg;
		next_ee = ee;
		next_pm = pm;
		next_int_mask = int_mask;
		next_int_status = int_status;
		next_pending = pending;
		next_state = state;
		next_read_seen = read_seen | REG_RD_IN;
		// Unaccepted writes vanish; the bus never waits
		wr_ok = REG_WR_IN && read_seen && state == pin_strap_pkg::PM_AWAKE;
		host_wake = state == pin_strap_pkg::PM_SLEEP && !CHIP_SELECT_N_IN
			&& !WRITE_STROBE_N_IN;
		rd_val = '0;
		if (hit(REG_ADDR_IN, `REG_PROBE)) begin
			rd_val = `PROBE_VALUE;
		end else if (hit(REG_ADDR_IN, `REG_PIN_CFG)) begin
			rd_val[`CFG_W-1:0] = cfg;
		end else if (hit(REG_ADDR_IN, `REG_EE_CTRL)) begin
			rd_val[`EE_W-1:0] = ee;
		end else if (hit(REG_ADDR_IN, `REG_PM_CTRL)) begin
			rd_val[`PM_W-1:0] = pm;
		end else if (hit(REG_ADDR_IN, `REG_STATUS)) begin
			rd_val[`ST_STRAP] = rs.strap;
			rd_val[`ST_SPEED100] = rs.strap;
			rd_val[`ST_AUTONEG] = rs.strap;
			rd_val[`ST_SWAP] = swap;
			rd_val[`ST_SLEEP] = state == pin_strap_pkg::PM_SLEEP;
			rd_val[`ST_EE_DIN] = din;
			rd_val[`ST_READ_SEEN] = read_seen;
		end else if (hit(REG_ADDR_IN, `REG_INT_STATUS)) begin
			rd_val[`INT_W-1:0] = int_status;
		end else if (hit(REG_ADDR_IN, `REG_INT_MASK)) begin
			rd_val[`INT_W-1:0] = int_mask;
		end
		next_rdata = REG_RD_IN ? rd_val : '0;
		if (REG_RD_IN && hit(REG_ADDR_IN, `REG_INT_STATUS)) begin
			next_int_status = '0;
		end
		if (wr_ok) begin
			if (hit(REG_ADDR_IN, `REG_PIN_CFG)) begin
				next_cfg = REG_WDATA_IN[`CFG_W-1:0];
			end
			if (hit(REG_ADDR_IN, `REG_EE_CTRL)) begin
				next_ee = REG_WDATA_IN[`EE_W-1:0];
			end
			if (hit(REG_ADDR_IN, `REG_INT_MASK)) begin
				next_int_mask = REG_WDATA_IN[`INT_W-1:0];
			end
			if (hit(REG_ADDR_IN, `REG_PM_CTRL)) begin
				next_pm = REG_WDATA_IN[`PM_W-1:0];
				if (REG_WDATA_IN[`PM_SLEEP]) begin
					next_state = pin_strap_pkg::PM_SLEEP;
					next_read_seen = 1'b0;
					next_pending = 1'b0;
				end
			end
		end
		// Sets come last so an event beats a same-cycle read clear
		if (REG_WR_IN && !wr_ok && state == pin_strap_pkg::PM_AWAKE) begin
			next_int_status[`INT_WR_DROPPED] = 1'b1;
		end
		case (state)
			pin_strap_pkg::PM_SLEEP: begin
				if (host_wake) begin
					next_state = pin_strap_pkg::PM_AWAKE;
					next_read_seen = 1'b0;
					next_pending = 1'b0;
					next_int_status[`INT_HOST_WAKE] = 1'b1;
				end else if (pm[`PM_WAKE_EN] && WAKE_EVENT_IN) begin
					next_pending = 1'b1;
					next_int_status[`INT_WAKE_EVENT] = 1'b1;
				end
			end
			pin_strap_pkg::PM_AWAKE: begin
			end
			default: begin
				next_state = pin_strap_pkg::PM_AWAKE;
			end
		endcase
		next_irq = |(next_int_status & next_int_mask);
	end

	always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			cfg <= `CFG_RESET;
			ee <= `EE_RESET;
			pm <= `PM_RESET;
			int_status <= `INT_RESET;
			int_mask <= `INT_RESET;
			rdata <= '0;
			read_seen <= 1'b0;
			pending <= 1'b0;
			irq <= 1'b0;
			state <= pin_strap_pkg::PM_AWAKE;
		end else begin
			cfg <= next_cfg;
			ee <= next_ee;
			pm <= next_pm;
			int_status <= next_int_status;
			int_mask <= next_int_mask;
			rdata <= next_rdata;
			read_seen <= next_read_seen;
			pending <= next_pending;
			irq <= next_irq;
			state <= next_state;
		end
	end

	always_comb begin
		next_d_oe_n = 1'b0;
		case (drole)
			pin_strap_pkg::DATA_EEPROM: begin
				next_d_out = ee[`EE_DOUT];
				next_d_oe_n = !ee[`EE_DOE];
			end
			pin_strap_pkg::DATA_GPO: next_d_out = cfg[`CFG_GENERAL_OUTPUT_THREE];
			pin_strap_pkg::DATA_TX_EN: next_d_out = MII_TX_EN_IN;
			pin_strap_pkg::DATA_TX_CLK: next_d_out = MII_TX_CLK_IN;
			default: next_d_out = 1'b0;
		endcase
		case (crole)
			pin_strap_pkg::CLK_EEPROM: next_c_out = ee[`EE_CLK];
			pin_strap_pkg::CLK_GPO: next_c_out = cfg[`CFG_GENERAL_OUTPUT_FOUR];
			pin_strap_pkg::CLK_RX_DV: next_c_out = MII_RX_DV_IN;
			pin_strap_pkg::CLK_RX_CLK: next_c_out = MII_RX_CLK_IN;
			default: next_c_out = 1'b0;
		endcase
		// Any alternate role parks the EEPROM deselected
		next_sel = ee[`EE_SEL] && drole == pin_strap_pkg::DATA_EEPROM
			&& crole == pin_strap_pkg::CLK_EEPROM;
		// Data line only reads back while it serves the EEPROM
		next_din = EEPROM_DATA_PIN_IN && drole == pin_strap_pkg::DATA_EEPROM;
		next_swap = (cfg[`CFG_MDIX_AUTO] && LINK_REVERSED_IN)
			|| cfg[`CFG_MDIX_MANUAL];
		w_lvl = pending ? pm[`PM_POL] : !pm[`PM_POL];
		if (pm[`PM_OD]) begin
			next_w_out = 1'b0;
			next_w_oe_n = w_lvl;
		end else begin
			next_w_out = w_lvl;
			next_w_oe_n = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			d_out <= 1'b0;
			d_oe_n <= 1'b1;
			c_out <= 1'b0;
			sel <= 1'b0;
			swap <= 1'b0;
			w_out <= 1'b1;
			w_oe_n <= 1'b0;
			din <= 1'b0;
		end else begin
			d_out <= next_d_out;
			d_oe_n <= next_d_oe_n;
			c_out <= next_c_out;
			sel <= next_sel;
			swap <= next_swap;
			w_out <= next_w_out;
			w_oe_n <= next_w_oe_n;
			din <= next_din;
		end
	end

	assign REG_RDATA_OUT = rdata;
	assign EEPROM_DATA_PIN_OUT = d_out;
	assign EEPROM_DATA_PIN_OE_N_OUT = d_oe_n;
	assign EEPROM_CLOCK_PIN_OUT = c_out;
	assign EEPROM_SELECT_OUT = sel;
	assign WAKE_INDICATOR_OUT = w_out;
	assign WAKE_INDICATOR_OE_N_OUT = w_oe_n;
	assign PAIR_A_TRANSMIT_OUT = !swap;
	assign PAIR_B_TRANSMIT_OUT = swap;
	// Defaults follow the strap; duplex is half either way
	assign LINK_SPEED_100_OUT = rs.strap;
	assign LINK_AUTONEG_OUT = rs.strap;
	assign LINK_FULL_DUPLEX_OUT = 1'b0;
	assign SLEEPING_OUT = state == pin_strap_pkg::PM_SLEEP;
	assign IRQ_OUT = irq;

	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (!rst_n);

	sequence s_host_write;
		state == pin_strap_pkg::PM_SLEEP && !CHIP_SELECT_N_IN && !WRITE_STROBE_N_IN;
	endsequence
	sequence s_armed_event;
		state == pin_strap_pkg::PM_SLEEP && pm[`PM_WAKE_EN] && WAKE_EVENT_IN
			&& CHIP_SELECT_N_IN;
	endsequence

	AST_LINK_DEFAULT: assert property (
		rs.strap_valid |-> (LINK_SPEED_100_OUT == rs.strap
			&& LINK_AUTONEG_OUT == rs.strap && !LINK_FULL_DUPLEX_OUT))
		else $error("link defaults do not follow strap");
	AST_SWAP_MANUAL: assert property (
		cfg[`CFG_MDIX_MANUAL] |=> (PAIR_B_TRANSMIT_OUT && !PAIR_A_TRANSMIT_OUT))
		else $error("manual crossover did not swap pairs");
	AST_GENERAL_OUTPUT_THREE_VALUE: assert property (
		drole == pin_strap_pkg::DATA_GPO |=> EEPROM_DATA_PIN_OUT
			== $past(cfg[`CFG_GENERAL_OUTPUT_THREE]))
		else $error("general output three value wrong");
	AST_RX_DV_MON: assert property (
		crole == pin_strap_pkg::CLK_RX_DV |=> EEPROM_CLOCK_PIN_OUT
			== $past(MII_RX_DV_IN))
		else $error("clock pin does not mirror receive valid");
	AST_SEL_DATA_ROLE: assert property (
		drole != pin_strap_pkg::DATA_EEPROM |=> !EEPROM_SELECT_OUT)
		else $error("select asserted in data pin alternate role");
	AST_SEL_CLK_ROLE: assert property (
		crole != pin_strap_pkg::CLK_EEPROM |=> !EEPROM_SELECT_OUT)
		else $error("select asserted in clock pin alternate role");
	AST_NO_INPUT: assert property (
		drole != pin_strap_pkg::DATA_EEPROM |=> !EEPROM_DATA_PIN_OE_N_OUT)
		else $error("data pin released in output role");
	AST_WRITE_BEFORE_READ: assert property (
		(REG_WR_IN && !read_seen) |=> $stable(cfg) && $stable(int_mask))
		else $error("write carried out before first read");
	AST_WAKE_PIN: assert property (
		(s_armed_event ##1 (!pm[`PM_OD] && state == pin_strap_pkg::PM_SLEEP
			&& CHIP_SELECT_N_IN)) |=> WAKE_INDICATOR_OUT == pm[`PM_POL])
		else $error("wake indicator not asserted");
	AST_STAY_ASLEEP: assert property (
		(state == pin_strap_pkg::PM_SLEEP && (CHIP_SELECT_N_IN
			|| WRITE_STROBE_N_IN)) |=> state == pin_strap_pkg::PM_SLEEP)
		else $error("left sleep without host write");
	AST_HOST_WAKE: assert property (
		s_host_write |=> (state == pin_strap_pkg::PM_AWAKE && !read_seen
			&& !pending))
		else $error("host write did not wake the device");
endmodule // pin_strap_mux_wake_control
`default_nettype wire

// [verif/eeprom_partner.sv]
// Serial EEPROM stand-in on the shared data pin
`timescale 1ns/10ps
`default_nettype none
module eeprom_partner #(
	parameter logic READ_BIT = 1'b1
) (
	// Clock
	input wire logic clk_in,
	// Device side of the pin
	input wire logic select_in,
	input wire logic data_out_in,
	input wire logic data_oe_n_in,
	// Resolved pin level
	output logic pin_level_out
);
	// Known start so a floating line toggles instead of staying unknown
	logic last_level = 1'b0;
	always_ff @(posedge clk_in) begin
		last_level <= pin_level_out;
	end
	// Released and unselected: no pull, so show a changing level
	assign pin_level_out = !data_oe_n_in ? data_out_in :
		(select_in ? READ_BIT : ~last_level);
endmodule // eeprom_partner
`default_nettype wire

// [verif/pin_strap_mux_wake_control_tb.sv]
// Register-level bench for strap, pin mux, crossover and wake logic
`timescale 1ns/10ps
`default_nettype none
`include "pin_strap_params.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	n_errors++; $display("FAIL %s expected %h seen %h", nm, e, g); end end
module pin_strap_mux_wake_control_tb;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic strap = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdat;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic cs_n = 1'b1;
	logic wr_n = 1'b1;
	logic wake_ev = 1'b0;
	logic por_n = 1'b1;
	logic rev = 1'b0;
	logic [3:0] mii = 4'h0;
	logic [31:0] rdata;
	logic pin_level, d_out, d_oe_n, c_out, sel, wk, wk_oe_n;
	logic pa, pb, spd, fdx, aneg, slp, irq;
	int n_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	pin_strap_mux_wake_control dut (.SYS_CLK_IN(clk), .ARST_N_IN(arst_n),
		.POWER_ON_RESET_N_IN(por_n), .LINK_DEFAULT_STRAP_IN(strap),
		.REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr),
		.REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .CHIP_SELECT_N_IN(cs_n),
		.WRITE_STROBE_N_IN(wr_n), .WAKE_EVENT_IN(wake_ev),
		.LINK_REVERSED_IN(rev), .MII_TX_EN_IN(mii[0]),
		.MII_TX_CLK_IN(mii[1]), .MII_RX_DV_IN(mii[2]),
		.MII_RX_CLK_IN(mii[3]), .EEPROM_DATA_PIN_IN(pin_level),
		.EEPROM_DATA_PIN_OUT(d_out), .EEPROM_DATA_PIN_OE_N_OUT(d_oe_n),
		.EEPROM_CLOCK_PIN_OUT(c_out), .EEPROM_SELECT_OUT(sel),
		.WAKE_INDICATOR_OUT(wk), .WAKE_INDICATOR_OE_N_OUT(wk_oe_n),
		.PAIR_A_TRANSMIT_OUT(pa), .PAIR_B_TRANSMIT_OUT(pb),
		.LINK_SPEED_100_OUT(spd), .LINK_FULL_DUPLEX_OUT(fdx),
		.LINK_AUTONEG_OUT(aneg), .SLEEPING_OUT(slp), .IRQ_OUT(irq));
	eeprom_partner eeprom (.clk_in(clk), .select_in(sel),
		.data_out_in(d_out), .data_oe_n_in(d_oe_n),
		.pin_level_out(pin_level));
	always #10 clk = ~clk;
	// Ceiling well above the few hundred cycles the sequence needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			final_report();
		end
	end
	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic do_reset(input logic s);
		@(posedge clk);
		arst_n <= 1'b0;
		strap <= s;
		settle(8);
		`CHK("select in reset", 1'b0, sel)
		`CHK("data oe_n in reset", 1'b1, d_oe_n)
		@(posedge clk);
		arst_n <= 1'b1;
		settle(4);
		`CHK("speed100", s, spd)
		`CHK("autoneg", s, aneg)
		`CHK("full duplex", 1'b0, fdx)
	endtask
	initial begin
		do_reset(1'b1);
		reg_wr(`REG_PIN_CFG, 32'h0000_0000);
		reg_rd(`REG_PIN_CFG, rdat);
		`CHK("cfg after early write", 32'h0000_0080, rdat)
		reg_rd(`REG_INT_STATUS, rdat);
		`CHK("dropped write flag", 32'h0000_0004, rdat)
		reg_rd(`REG_INT_STATUS, rdat);
		`CHK("status cleared", 32'h0000_0000, rdat)
		reg_rd(8'h3C, rdat);
		`CHK("unmapped read", 32'h0000_0000, rdat)
		reg_wr(`REG_INT_MASK, 32'h0000_0003);
		reg_rd(`REG_PROBE, rdat);
		`CHK("probe", `PROBE_VALUE, rdat)
		// Each role picks a distinct source bit
		mii <= 4'b1001;
		reg_wr(`REG_EE_CTRL, 32'h0000_000D);
		for (int k = 0; k < 16; k++) begin
			reg_wr(`REG_PIN_CFG, 32'h0000_0020 | k);
			settle(2);
			`CHK("data pin", 4'b0101 >> k[1:0] & 4'h1, {3'h0, d_out})
			`CHK("clock pin", 4'b1010 >> k[3:2] & 4'h1, {3'h0, c_out})
			`CHK("select", k == 0, sel)
			`CHK("data drives", 1'b0, d_oe_n)
		end
		reg_wr(`REG_PIN_CFG, 32'h0000_0022);
		reg_rd(`REG_STATUS, rdat);
		`CHK("no input in monitor role", 32'h0000_0047, rdat)
		reg_wr(`REG_EE_CTRL, 32'h0000_0005);
		reg_wr(`REG_PIN_CFG, 32'h0000_0000);
		settle(2);
		`CHK("data released", 1'b1, d_oe_n)
		reg_rd(`REG_STATUS, rdat);
		`CHK("status", 32'h0000_0067, rdat)
		for (int k = 0; k < 8; k++) begin
			rev <= k[0];
			reg_wr(`REG_PIN_CFG, {24'h00_0000, k[2:1], 6'h00});
			settle(2);
			`CHK("pair b tx", k[1] | (k[2] & k[0]), pb)
			`CHK("pair a tx", !(k[1] | (k[2] & k[0])), pa)
		end
		reg_wr(`REG_PM_CTRL, 32'h0000_000B);
		settle(2);
		`CHK("asleep", 1'b1, slp)
		wake_ev <= 1'b1;
		@(posedge clk);
		wake_ev <= 1'b0;
		settle(3);
		`CHK("indicator", 1'b1, wk)
		`CHK("indicator drive", 1'b0, wk_oe_n)
		`CHK("irq on wake event", 1'b1, irq)
		settle(5);
		`CHK("still asleep", 1'b1, slp)
		@(posedge clk);
		cs_n <= 1'b0;
		wr_n <= 1'b0;
		addr <= `REG_PROBE;
		@(posedge clk);
		cs_n <= 1'b1;
		wr_n <= 1'b1;
		settle(2);
		`CHK("awake", 1'b0, slp)
		`CHK("indicator off", 1'b0, wk)
		reg_wr(`REG_INT_MASK, 32'h0000_0000);
		reg_rd(`REG_INT_STATUS, rdat);
		`CHK("wake flags", 32'h0000_0007, rdat)
		settle(2);
		`CHK("irq cleared", 1'b0, irq)
		reg_rd(`REG_INT_MASK, rdat);
		`CHK("mask kept", 32'h0000_0003, rdat)
		// Open drain, active low indicator
		reg_wr(`REG_PM_CTRL, 32'h0000_000D);
		settle(2);
		`CHK("od released", 1'b1, wk_oe_n)
		`CHK("od level", 1'b0, wk)
		@(posedge clk);
		wake_ev <= 1'b1;
		@(posedge clk);
		wake_ev <= 1'b0;
		settle(3);
		`CHK("od asserted", 1'b0, wk_oe_n)
		`CHK("od still asleep", 1'b1, slp)
		@(posedge clk);
		por_n <= 1'b0;
		settle(2);
		`CHK("por awake", 1'b0, slp)
		`CHK("por indicator drive", 1'b0, wk_oe_n)
		@(posedge clk);
		por_n <= 1'b1;
		do_reset(1'b0);
		reg_rd(`REG_INT_MASK, rdat);
		`CHK("mask reset", 32'h0000_0000, rdat)
		reg_rd(`REG_PIN_CFG, rdat);
		`CHK("cfg reset", 32'h0000_0080, rdat)
		final_report();
	end
endmodule // pin_strap_mux_wake_control_tb
`default_nettype wire
